// >>> rtl/tsc_top.sv
`timescale 1ns/10ps
`include "tsc_regs.svh"
module tsc_top
  import tsc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic interrupt_out_n,
  input wire logic [11:0] button_touched,
  input wire logic button_touch_irq_en,
  input wire logic button_release_irq_en,
  input wire logic slider_touched,
  input wire logic slider_move_up,
  input wire logic slider_move_down,
  input wire logic [15:0] slider_pos_in,
  input wire logic [7:0] gpi_pins,
  input wire logic [7:0] gpi_mask,
  input wire logic [15:0] input_edge_select,
  input wire logic burn_done,
  input wire logic spm_write_done,
  input wire logic comp_done,
  input wire logic mode_entered,
  input wire logic comp_running,
  input wire logic [1:0] current_mode,
  input wire logic stored_params_valid,
  input wire logic [2:0] burn_counter,
  input wire logic [7:0] output_powerup_state,
  input wire logic [7:0] gpo_mask,
  input wire logic autolight_on,
  input wire logic phase_start,
  output logic mode_req,
  output logic [1:0] mode_code,
  output logic comp_start,
  output logic [7:0] gpo_on
);
  // ************************************************************
  // Pin synchronisers and interrupt flags.
  // ************************************************************
  tsc_flag_if fl (); // Link to the flag block.
  logic [9:0] sy; // Synchronised scl, sda and input pins.

  tsc_sync #(.W(`TSC_SYNC_W)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .din({gpi_pins, sda_in, scl}),
    .dout(sy)
  );

  tsc_flags u_flags (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .fl(fl.owner)
  );

  // ************************************************************
  // State and decoded strobes.
  // ************************************************************
  tsc_top_s r; // Registered state of the bank.
  tsc_top_s next_r; // Next state.
  logic [6:0] set_v; // Event pulses toward the flags.
  logic rd_clr; // Flag register loaded for the host.
  logic wr_take; // A data byte was written.
  logic [7:0] gpi_lvl; // Levels of pins used as inputs.
  logic scl_s; // Synchronised clock line.
  logic sda_s; // Synchronised data line.

  assign scl_s = sy[0];
  assign sda_s = sy[1];
  assign gpi_lvl = sy[9:2] & gpi_mask;

  // Stored parameters count as in use only for burn counts one to three.
  function automatic logic params_in_use(input logic [2:0] cnt);
    params_in_use = stored_params_valid && cnt != 3'h0 &&
      cnt < `TSC_BURN_MAX;
  endfunction

  // Read value of each register; reserved and unmapped bytes read zero.
  function automatic logic [7:0] rd_value(input logic [7:0] a,
                                          input tsc_top_s s);
    unique case (a)
      `TSC_REG_IRQ: rd_value = {1'b0, fl.flags};
      `TSC_REG_STAT_HI:
        rd_value = {1'b0, s.move_hi, s.move_lo, slider_touched,
                    button_touched[11:8]};
      `TSC_REG_STAT_LO: rd_value = button_touched[7:0];
      `TSC_REG_POS_HI: rd_value = s.sld_pos[15:8];
      `TSC_REG_POS_LO: rd_value = s.sld_pos[7:0];
      `TSC_REG_GPI: rd_value = gpi_lvl;
      `TSC_REG_PARAM:
        rd_value = {4'h0, params_in_use(burn_counter), burn_counter};
      `TSC_REG_CTRL:
        rd_value = {5'h00, comp_running | s.comp_pend,
                    current_mode};
      `TSC_REG_GPO: rd_value = s.gpo_ctrl;
      default: rd_value = 8'h00;
    endcase
  endfunction

  // ************************************************************
  // Next-state logic: events, serial byte engine, phase updates.
  // ************************************************************
  always_comb begin
    logic [11:0] btn_on;
    logic [11:0] btn_off;
    logic [7:0] rise;
    logic [7:0] fall;
    logic gpi_hit;
    logic [7:0] byte_in;
    logic s_rise;
    logic s_fall;
    logic s_start;
    logic s_stop;
    logic load_tx;
    btn_on = 12'h000;
    btn_off = 12'h000;
    rise = 8'h00;
    fall = 8'h00;
    gpi_hit = 1'b0;
    byte_in = {r.shreg[6:0], sda_s};
    load_tx = 1'b0;
    next_r = r;
    set_v = 7'h00;
    rd_clr = 1'b0;
    wr_take = 1'b0;

    // Button and input pin edges are only trusted once the previous levels are primed.
    next_r.primed = 1'b1;
    next_r.btn_prev = button_touched;
    next_r.sld_prev = slider_touched;
    next_r.gpi_prev = gpi_lvl;
    if (r.primed) begin
      btn_on = button_touched & ~r.btn_prev;
      btn_off = r.btn_prev & ~button_touched;
      rise = gpi_lvl & ~r.gpi_prev;
      fall = r.gpi_prev & ~gpi_lvl;
    end
    for (int i = 0; i < 8; i++) begin
      gpi_hit = gpi_hit | (rise[i] & input_edge_select[2*i]) |
        (fall[i] & input_edge_select[2*i+1]);
    end
    // Events from the scan engine arrive within its own scan period.
    set_v[`TSC_IRQ_BURN] = burn_done;
    set_v[`TSC_IRQ_SPMW] = spm_write_done;
    set_v[`TSC_IRQ_GPI] = gpi_hit;
    set_v[`TSC_IRQ_SLD] = (slider_touched ^ r.sld_prev) |
      (slider_touched & (slider_move_up | slider_move_down |
       (slider_pos_in != r.sld_pos)));
    set_v[`TSC_IRQ_BTN] = (|btn_on & button_touch_irq_en) |
      (|btn_off & button_release_irq_en);
    set_v[`TSC_IRQ_COMP] = comp_done;
    set_v[`TSC_IRQ_MODE] = mode_entered;

    // Position tracks while touched and holds the last value after.
    if (slider_touched) begin
      next_r.sld_pos = slider_pos_in;
      if (slider_move_up) begin
        next_r.move_hi = 1'b1;
        next_r.move_lo = 1'b0;
      end else if (slider_move_down) begin
        next_r.move_lo = 1'b1;
        next_r.move_hi = 1'b0;
      end
    end else begin
      next_r.move_hi = 1'b0;
      next_r.move_lo = 1'b0;
    end

    // Output control starts from the power-up pattern, caught once.
    if (!r.primed) begin
      next_r.gpo_ctrl = output_powerup_state;
    end

    // Pending host writes are applied when the next phase begins.
    next_r.mode_req = 1'b0;
    next_r.comp_start = 1'b0;
    if (phase_start) begin
      if (r.mode_pend_v) begin
        next_r.mode_req = 1'b1;
        next_r.mode_code = r.mode_pend;
        next_r.mode_pend_v = 1'b0;
      end
      if (r.comp_pend) begin
        next_r.comp_start = 1'b1;
        next_r.comp_pend = 1'b0;
      end
      next_r.gpo_on = autolight_on ? 8'h00 :
        (r.gpo_ctrl & gpo_mask);
    end

    // Serial line conditions seen on the synchronised lines.
    next_r.scl_d = scl_s;
    next_r.sda_d = sda_s;
    s_rise = scl_s & ~r.scl_d;
    s_fall = ~scl_s & r.scl_d;
    s_start = scl_s & r.scl_d & r.sda_d & ~sda_s;
    s_stop = scl_s & r.scl_d & ~r.sda_d & sda_s;

    if (s_start) begin
      next_r.st = TSC_RX;
      next_r.kind = TSC_K_SADDR;
      next_r.bitcnt = 3'h0;
      next_r.ack_on = 1'b0;
    end else if (s_stop) begin
      next_r.st = TSC_IDLE;
      next_r.ack_on = 1'b0;
    end else begin
      unique case (r.st)
        TSC_IDLE: begin
          next_r.ack_on = 1'b0;
        end
        TSC_RX: begin
          if (s_rise) begin
            next_r.shreg = byte_in;
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == `TSC_BIT_LAST) begin
              next_r.st = TSC_ACK;
              unique case (r.kind)
                TSC_K_SADDR: begin
                  next_r.rw = byte_in[0];
                  if (byte_in[7:1] != `TSC_SLAVE_ADDR) begin
                    next_r.st = TSC_IDLE;
                  end
                end
                TSC_K_RADDR: begin
                  next_r.reg_addr = byte_in;
                end
                TSC_K_WDATA: begin
                  wr_take = 1'b1;
                  next_r.reg_addr = r.reg_addr + `TSC_ADDR_STEP;
                end
                default: begin
                  next_r.st = TSC_IDLE;
                end
              endcase
            end
          end
        end
        TSC_ACK: begin
          // Acknowledge is driven from one falling edge to the next.
          if (s_fall) begin
            next_r.ack_on = ~r.ack_on;
            if (r.ack_on) begin
              if (r.rw && r.kind == TSC_K_SADDR) begin
                load_tx = 1'b1;
              end else begin
                next_r.st = TSC_RX;
                next_r.bitcnt = 3'h0;
                next_r.kind = (r.kind == TSC_K_SADDR) ?
                  TSC_K_RADDR : TSC_K_WDATA;
              end
            end
          end
        end
        TSC_TX: begin
          if (s_fall) begin
            if (r.bitcnt == `TSC_BIT_LAST) begin
              next_r.st = TSC_RACK;
            end else begin
              next_r.txreg = {r.txreg[6:0], 1'b0};
              next_r.bitcnt = r.bitcnt + 3'h1;
            end
          end
        end
        TSC_RACK: begin
          if (s_rise) begin
            next_r.mack = ~sda_s;
          end
          if (s_fall) begin
            if (r.mack) begin
              load_tx = 1'b1;
            end else begin
              next_r.st = TSC_IDLE;
            end
          end
        end
        default: begin
          next_r.st = TSC_IDLE;
        end
      endcase
    end

    // Loading a byte for the host steps the address past it.
    if (load_tx) begin
      next_r.st = TSC_TX;
      next_r.bitcnt = 3'h0;
      next_r.txreg = rd_value(r.reg_addr, r);
      next_r.reg_addr = r.reg_addr + `TSC_ADDR_STEP;
      rd_clr = (r.reg_addr == `TSC_REG_IRQ);
    end

    // Register writes; read-only and unmapped offsets are ignored.
    if (wr_take) begin
      if (r.reg_addr == `TSC_REG_CTRL) begin
        // The reserved mode code is dropped rather than forwarded.
        if (byte_in[1:0] != `TSC_MODE_RSVD) begin
          next_r.mode_pend = byte_in[1:0];
          next_r.mode_pend_v = 1'b1;
        end
        if (byte_in[`TSC_CTRL_COMP]) begin
          next_r.comp_pend = 1'b1;
        end
      end else if (r.reg_addr == `TSC_REG_GPO) begin
        next_r.gpo_ctrl = byte_in;
      end
    end
  end

  // Synchronous reset; every field starts at zero and the engine idle.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************
  assign fl.set = set_v;
  assign fl.clr = rd_clr;
  assign interrupt_out_n = fl.irq_n;
  assign sda_out = 1'b0;
  assign sda_oe = r.ack_on | (r.st == TSC_TX && !r.txreg[7]);
  assign mode_req = r.mode_req;
  assign mode_code = r.mode_code;
  assign comp_start = r.comp_start;
  assign gpo_on = r.gpo_on;

  // ************************************************************
  // Checks.
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_byte_written;
    ce && wr_take;
  endsequence
  sequence s_phase_manual;
    ce && phase_start && !autolight_on;
  endsequence

  a_burn_flag_set: assert property (
    ce && burn_done |=> fl.flags[`TSC_IRQ_BURN])
    else $error("burn flag not set");
  a_comp_flag_set: assert property (
    ce && comp_done |=> fl.flags[`TSC_IRQ_COMP] && !interrupt_out_n)
    else $error("compensation flag not set");
  a_mode_flag_set: assert property (
    ce && mode_entered |=> fl.flags[`TSC_IRQ_MODE])
    else $error("mode flag not set");
  a_addr_steps_one: assert property (
    s_byte_written |=> r.reg_addr == $past(r.reg_addr) + `TSC_ADDR_STEP)
    else $error("address did not step after write");
  a_gpo_at_phase: assert property (
    s_phase_manual |=> gpo_on == ($past(r.gpo_ctrl) & $past(gpo_mask)))
    else $error("output control not applied at phase");
  a_pos_held_idle: assert property (
    ce && !slider_touched |=> r.sld_pos == $past(r.sld_pos))
    else $error("position changed while released");
  a_move_drops: assert property (
    ce && !slider_touched |=> !r.move_hi && !r.move_lo)
    else $error("move status kept after release");
endmodule

// >>> rtl/tsc_regs.svh
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

// ************************************************************
// Register offsets on the serial register port.
// ************************************************************
`define TSC_REG_IRQ 8'h00
`define TSC_REG_STAT_HI 8'h01
`define TSC_REG_STAT_LO 8'h02
`define TSC_REG_POS_HI 8'h03
`define TSC_REG_POS_LO 8'h04
`define TSC_REG_GPI 8'h07
`define TSC_REG_PARAM 8'h08
`define TSC_REG_CTRL 8'h09
`define TSC_REG_GPO 8'h0A

// ************************************************************
// Field positions, codes and counts.
// ************************************************************
`define TSC_SLAVE_ADDR 7'h2B
`define TSC_IRQ_BURN 6
`define TSC_IRQ_SPMW 5
`define TSC_IRQ_GPI 4
`define TSC_IRQ_SLD 3
`define TSC_IRQ_BTN 2
`define TSC_IRQ_COMP 1
`define TSC_IRQ_MODE 0
`define TSC_CTRL_COMP 2
`define TSC_MODE_RSVD 2'h3
`define TSC_BURN_MAX 3'h4
`define TSC_BIT_LAST 3'h7
`define TSC_ADDR_STEP 8'h01
`define TSC_SYNC_W 10

`endif

// >>> rtl/tsc_pkg.sv
package tsc_pkg;

  // Serial port byte engine states.
  typedef enum logic [2:0] {
    TSC_IDLE, TSC_RX, TSC_ACK, TSC_TX, TSC_RACK
  } tsc_bus_e;

  // Meaning of the next byte received from the host.
  typedef enum logic [1:0] {
    TSC_K_SADDR, TSC_K_RADDR, TSC_K_WDATA
  } tsc_kind_e;

  // Whole state of the top-level register bank.
  typedef struct packed {
    tsc_bus_e st; tsc_kind_e kind;
    logic ack_on; logic rw; logic mack; logic [2:0] bitcnt;
    logic [7:0] shreg; logic [7:0] txreg; logic [7:0] reg_addr;
    logic scl_d; logic sda_d; logic primed;
    logic [11:0] btn_prev; logic sld_prev; logic [15:0] sld_pos;
    logic move_hi; logic move_lo; logic [7:0] gpi_prev;
    logic [7:0] gpo_ctrl; logic [7:0] gpo_on;
    logic [1:0] mode_pend; logic mode_pend_v; logic comp_pend;
    logic mode_req; logic [1:0] mode_code; logic comp_start;
  } tsc_top_s;

  // Whole state of the interrupt flag block.
  typedef struct packed {
    logic [6:0] flags; logic irq_n;
  } tsc_flag_s;

endpackage

// >>> rtl/tsc_flag_if.sv
`timescale 1ns/10ps
// Event sets, read clear and flag view between bank and flag block.
interface tsc_flag_if;
  logic [6:0] set;   // One-cycle event pulses, one per flag.
  logic clr;         // Host read of the flag register.
  logic [6:0] flags; // Sticky flags.
  logic irq_n;       // Interrupt level, low while any flag is set.
  modport owner (input set, input clr, output flags, output irq_n);
  modport user (output set, output clr, input flags, input irq_n);
endinterface

// >>> rtl/tsc_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser; a bit changes once stages two and three agree.
module tsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // ************************************************************
  // State.
  // ************************************************************
  typedef struct packed {
    logic [W-1:0] s1; logic [W-1:0] s2; logic [W-1:0] s3;
    logic [W-1:0] stable;
  } tsc_sync_s;

  tsc_sync_s r; // Registered state.
  tsc_sync_s next_r; // Next state.

  // The first stage feeds only the second; agreement filters glitches.
  always_comb begin
    next_r = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.stable[i] = r.s3[i];
      end
    end
  end

  // Idle lines are high, so every stage resets to one.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '1;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign dout = r.stable;
endmodule

// >>> rtl/tsc_flags.sv
`timescale 1ns/10ps
// Sticky interrupt flags with a set-over-clear priority.
module tsc_flags
  import tsc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  tsc_flag_if.owner fl
);
  tsc_flag_s r; // Registered flags and pin level.
  tsc_flag_s next_r; // Next value.

  // A read clears every flag, but an event in that cycle survives it.
  always_comb begin
    next_r.flags = (r.flags & ~{7{fl.clr}}) | fl.set;
    next_r.irq_n = ~|next_r.flags;
  end

  // Flags reset inactive and the pin released.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '{flags: '0, irq_n: 1'b1};
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign fl.flags = r.flags;
  assign fl.irq_n = r.irq_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_irq_follows_flags: assert property (
    fl.irq_n == (fl.flags == '0))
    else $error("interrupt pin disagrees with flags");
  a_read_clears_all: assert property (
    ce && fl.clr && fl.set == '0 |=> fl.flags == '0 && fl.irq_n)
    else $error("flag read did not clear flags");
  a_set_beats_clear: assert property (
    ce && fl.set != '0 |=> (fl.flags & $past(fl.set)) == $past(fl.set))
    else $error("event lost");
endmodule

// >>> tb/tsc_host.sv
`timescale 1ns/10ps
`include "tsc_regs.svh"
// ****
// Serial host model: drives scl, pulls the data line low or lets go.
// ****
module tsc_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  logic [7:0] rbuf [0:3]; // Bytes of the last read.
  logic nak; // Sticky: a byte the host sent was not acknowledged.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nak = 1'b0;
  end
  // One bit in 200 ns. The device moves the line about five clocks after
  // it sees scl fall, so scl stays low for 150 ns before it rises.
  task automatic bit_io(input logic b, output logic r);
    #50 sda_low = ~b;
    #100 scl = 1'b1;
    #40 r = sda;
    #10 scl = 1'b0;
  endtask
  // Start or repeated start; scl idles high between frames.
  // The line is let go early so a lagging ack is gone before scl rises.
  task automatic start;
    #100 sda_low = 1'b0;
    #50 scl = 1'b1;
    #50 sda_low = 1'b1;
    #50 scl = 1'b0;
  endtask
  // Stop; scl rises only once the line is held low by the host.
  task automatic stop;
    #50 sda_low = 1'b1;
    #100 scl = 1'b1;
    #50 sda_low = 1'b0;
    #50;
  endtask
  // Eight data bits, then the ack bit given by ao.
  task automatic xfer(input logic [7:0] d, input logic ao,
                      output logic [7:0] q, output logic ai);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ao, ai);
  endtask
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic ai;
    xfer(d, 1'b1, q, ai);
    nak = nak | ai;
  endtask
  // Register write of one data byte; reserved bits are sent as given.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    send({`TSC_SLAVE_ADDR, 1'b0});
    send(a);
    send(d);
    stop();
  endtask
  // Burst read; the host acks all but the last byte.
  task automatic rd(input logic [7:0] a, input int n);
    logic ai;
    start();
    send({`TSC_SLAVE_ADDR, 1'b0});
    send(a);
    start();
    send({`TSC_SLAVE_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, i == n - 1, rbuf[i], ai);
    end
    stop();
  endtask
endmodule

// >>> tb/tsc_top_tb.sv
`timescale 1ns/10ps
// ****
// Bench for the touch status register bank.
// ****
module tsc_top_tb
  import tsc_pkg::*;
;
  logic clk, rstn, ce, scl, sda_low, sda_out, sda_oe, interrupt_out_n;
  logic [11:0] button_touched;
  logic touch_en, release_en, slider_touched, move_up, move_down;
  logic [15:0] slider_pos_in, input_edge_select;
  logic [7:0] gpi_pins, gpi_mask, powerup, gpo_mask, gpo_on;
  logic [3:0] ev; // Burn, memory write, compensation, mode pulses.
  logic comp_running, valid, autolight_on, phase_start, mode_req;
  logic comp_start;
  logic [1:0] current_mode, mode_code;
  logic [2:0] burn_counter;
  int err_total, n_tests, n_comp, n_mode, k;
  wire sda_line;
  // Open drain with pull-up: low if either side pulls.
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
  tsc_top tsc_top_inst (.clk(clk), .rstn(rstn), .ce(ce), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .interrupt_out_n(interrupt_out_n), .button_touched(button_touched),
    .button_touch_irq_en(touch_en), .button_release_irq_en(release_en),
    .slider_touched(slider_touched), .slider_move_up(move_up),
    .slider_move_down(move_down), .slider_pos_in(slider_pos_in),
    .gpi_pins(gpi_pins), .gpi_mask(gpi_mask),
    .input_edge_select(input_edge_select), .burn_done(ev[3]),
    .spm_write_done(ev[2]), .comp_done(ev[1]), .mode_entered(ev[0]),
    .comp_running(comp_running), .current_mode(current_mode),
    .stored_params_valid(valid), .burn_counter(burn_counter),
    .output_powerup_state(powerup), .gpo_mask(gpo_mask),
    .autolight_on(autolight_on), .phase_start(phase_start),
    .mode_req(mode_req), .mode_code(mode_code),
    .comp_start(comp_start), .gpo_on(gpo_on));
  tsc_host tsc_host_inst (.scl(scl), .sda_low(sda_low), .sda(sda_line));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Count the one-cycle requests towards the sensing core.
  always @(posedge clk) begin
    n_comp <= n_comp + int'(comp_start);
    n_mode <= n_mode + int'(mode_req);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    tsc_host_inst.rd(a, 1);
    chk(tsc_host_inst.rbuf[0], e);
  endtask
  task automatic phase;
    cyc(1);
    phase_start = 1'b1;
    cyc(1);
    phase_start = 1'b0;
    cyc(2);
  endtask
  task automatic results;
    $display("tests=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****
  // Main sequence.
  // ****
  initial begin
    {rstn, button_touched, slider_touched, move_up, move_down} = '0;
    {slider_pos_in, gpi_pins, gpi_mask, ev, comp_running} = '0;
    {current_mode, valid, burn_counter, autolight_on, phase_start} = '0;
    {err_total, n_tests, n_comp, n_mode} = '0;
    {ce, touch_en, release_en} = 3'h7;
    input_edge_select = 16'h0001; // Pin 0 rising only.
    powerup = 8'hA5;
    gpo_mask = 8'hFF;
    cyc(16);
    rstn = 1'b1;
    cyc(4);
    chk(interrupt_out_n, 1'b1);
    rdc(8'h03, 8'h00);
    phase();
    chk(gpo_on, 8'hA5);
    // A pulse while the clock enable is low is frozen out with the rest.
    ce = 1'b0;
    ev = 4'h8;
    cyc(1);
    ev = 4'h0;
    ce = 1'b1;
    cyc(2);
    chk(interrupt_out_n, 1'b1);
    // Each of the four pulse sources alone, then two at once.
    for (int i = 0; i < 5; i++) begin
      ev = (i < 4) ? 4'h1 << i : 4'hA;
      cyc(1);
      ev = 4'h0;
      cyc(2);
      chk(interrupt_out_n, 1'b0);
      k = (i == 4) ? 'h42 : 1 << ((i < 2) ? i : i + 3);
      rdc(8'h00, k[7:0]);
      chk(interrupt_out_n, 1'b1);
    end
    // Buttons and slider, read as one burst from the upper status.
    button_touched = 12'hA5C;
    slider_touched = 1'b1;
    slider_pos_in = 16'h1234;
    cyc(4);
    move_up = 1'b1;
    cyc(1);
    move_up = 1'b0;
    cyc(3);
    tsc_host_inst.rd(8'h01, 4);
    chk(tsc_host_inst.rbuf[0], 8'h5A);
    chk(tsc_host_inst.rbuf[1], 8'h5C);
    chk({tsc_host_inst.rbuf[2], tsc_host_inst.rbuf[3]}, 'h1234);
    rdc(8'h00, 8'h0C);
    move_down = 1'b1;
    cyc(1);
    move_down = 1'b0;
    cyc(3);
    rdc(8'h01, 8'h3A);
    slider_touched = 1'b0;
    slider_pos_in = 16'h9999;
    cyc(4);
    rdc(8'h04, 8'h34);
    rdc(8'h00, 8'h08);
    touch_en = 1'b0;
    button_touched = 12'hA5D;
    cyc(4);
    rdc(8'h00, 8'h00);
    button_touched = 12'hA5C;
    cyc(4);
    rdc(8'h00, 8'h04);
    // General-purpose inputs: mask, levels and selected edge.
    gpi_mask = 8'h0F;
    gpi_pins = 8'hF2;
    cyc(10);
    rdc(8'h07, 8'h02);
    rdc(8'h00, 8'h00);
    gpi_pins = 8'hF3;
    cyc(10);
    rdc(8'h00, 8'h10);
    // Parameter status over burn counts zero to four, valid and not.
    for (int v = 0; v < 2; v++) begin
      for (int c = 0; c < 5; c++) begin
        valid = v[0];
        burn_counter = c[2:0];
        cyc(2);
        k = (v == 1 && c > 0 && c < 4) ? 8 + c : c;
        rdc(8'h08, k[7:0]);
      end
    end
    // Compensation request, applied at the next phase only.
    // Its mode bits are zero, so it also requests Active once.
    tsc_host_inst.wr(8'h09, 8'h04);
    rdc(8'h09, 8'h04);
    chk(n_comp, 0);
    phase();
    chk(n_comp, 1);
    comp_running = 1'b1;
    current_mode = 2'h2;
    rdc(8'h09, 8'h06);
    // Mode codes 1, 2, reserved 3, then 0; one request is already counted.
    for (int m = 1; m < 5; m++) begin
      tsc_host_inst.wr(8'h09, {6'h00, m[1:0]});
      phase();
      chk(n_mode, (m < 3) ? m + 1 : m);
      chk(mode_code, (m == 3) ? 2'h2 : m[1:0]);
    end
    ev = 4'h1;
    cyc(1);
    ev = 4'h0;
    k = 0;
    while (interrupt_out_n !== 1'b0) begin
      cyc(1);
      k++;
      if (k > 50) begin
        err_total++;
        results();
      end
    end
    rdc(8'h00, 8'h01);
    // Manual output control, then automatic lighting.
    tsc_host_inst.wr(8'h0A, 8'h3C);
    chk(gpo_on, 8'hA5);
    // Only the low four pins are outputs now; the rest must be ignored.
    gpo_mask = 8'h0F;
    phase();
    chk(gpo_on, 8'h0C);
    autolight_on = 1'b1;
    phase();
    chk(gpo_on, 8'h00);
    // Read-only and unmapped places.
    tsc_host_inst.wr(8'h02, 8'hFF);
    rdc(8'h02, 8'h5C);
    rdc(8'h05, 8'h00);
    chk(tsc_host_inst.nak, 1'b0);
    results();
  end
endmodule
